// >>> src/frf_pkg.sv
// Constants, types and decode helpers for the flash read/reset front end
`default_nettype none
package frf_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NSEC   = 8;

  // APB register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CFG    = 8'h04;
  localparam logic [7:0] OFF_PROT   = 8'h08;
  localparam logic [7:0] OFF_PADDR  = 8'h0c;
  localparam logic [7:0] OFF_PDATA  = 8'h10;

  // Command codes on data bits 31:24
  localparam logic [7:0] CMD_RESET  = 8'hf0;
  localparam logic [7:0] CMD_CFG_RD = 8'hc6;
  localparam logic [7:0] CMD_CFG_WR = 8'hd0;
  localparam logic [7:0] CMD_PROT_RD = 8'h90;
  localparam logic [7:0] CMD_SECSI  = 8'h88;

  // Configuration word: burst enable and initial wait field
  localparam logic [15:0] CFG_RESET    = 16'h0400;
  localparam int          CFG_BURST_BIT = 15;
  localparam int          CFG_WAIT_LSB  = 10;
  localparam logic [4:0]  WAIT_OFFSET   = 5'h02;

  localparam int          SECSI_WORDS  = 64;
  localparam logic [31:0] CORRUPT_WORD = 32'h0bad0bad;

  // Internal busy times
  localparam int CLK_NS      = 10;
  localparam int PROG_NS     = 2000;
  localparam int RST_BUSY_NS = 500;
  localparam int PROG_CYC    = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_BUSY_CYC = (RST_BUSY_NS + CLK_NS - 1) / CLK_NS;

  // Values after reset
  localparam logic [NSEC-1:0] PPB_RESET = 8'h00;
  localparam logic [NSEC-1:0] DYB_RESET = 8'h00;

  typedef enum logic [1:0] {
    MD_ARRAY = 2'b00,
    MD_CFG   = 2'b01,
    MD_PROT  = 2'b11,
    MD_SECSI = 2'b10
  } frf_mode_t;

  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_WAIT = 2'b01,
    BS_DATA = 2'b11
  } frf_burst_t;

  function automatic logic [2:0] frf_sector(input logic [ADDR_W-1:0] a);
    frf_sector = a[ADDR_W-1 -: 3];
  endfunction

  function automatic logic frf_outer(input logic [2:0] s);
    frf_outer = (s == 3'h0) || (s == 3'h7);
  endfunction

  function automatic logic frf_known(input logic [7:0] a);
    frf_known = (a == OFF_STATUS) || (a == OFF_CFG) || (a == OFF_PROT) ||
                (a == OFF_PADDR) || (a == OFF_PDATA);
  endfunction

endpackage
`default_nettype wire

// >>> src/frf_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module frf_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // frf_sync
`default_nettype wire

// >>> src/frf_mem.sv
// Array storage with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module frf_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // frf_mem
`default_nettype wire

// >>> src/frf_top.sv
// Flash read/reset front end: pin decode, burst, reset, APB control
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Data driven only when selected and gated
// - Reset or power-up starts in async read
// - Async reads need no command, random order
// - Mode held until a command changes it
// - Reset pin aborts program and burst, returns mode and config to reset state
// - Data outputs float while reset pin low
// - Ready/busy low until reset handling done, only if reset hits while busy
// - Reset during program corrupts target word
// - Burst off until configuration written
// - Burst enabled makes array reads synchronous
// - Wait field sets clocks to first data
// - Secured sector same timing, bound invalid
// - Config and protection reads single, stable
// - Bit0 persistent, bit1 dynamic protection
// - Write-protect guards two outermost sectors
module frf_top
  import frf_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              chip_sel_n,
  input  wire logic              out_gate_n,
  input  wire logic              write_n,
  input  wire logic              address_valid_n,
  input  wire logic              burst_clk,
  input  wire logic              hw_reset_n,
  input  wire logic              write_prot_n,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  output logic                   ready_busy_n
);

  localparam int SW = 7 + AW + DATA_W;

  logic [SW-1:0]     sync_q;
  logic              s_ce_n, s_oe_n, s_we_n, s_adv_n;
  logic              s_fclk, s_rst_n, s_wp_n;
  logic [AW-1:0]     s_addr;
  logic [DATA_W-1:0] s_dq;
  logic              we_q, fclk_q, rst_q;
  logic              we_rise, fclk_rise, cmd_stb;
  frf_mode_t         mode;
  logic [15:0]       cfg;
  logic              burst_en;
  frf_burst_t        bs;
  logic [AW-1:0]     b_base;
  logic [2:0]        beat;
  logic [4:0]        wait_cnt;
  logic              burst_bad;
  logic [AW-1:0]     rd_addr;
  logic [DATA_W-1:0] mem_rdata;
  logic              mem_we;
  logic [AW-1:0]     mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [NSEC-1:0]   persistent_protect_bit, dynamic_protect_bit;
  logic [AW-1:0]     prog_addr;
  logic [DATA_W-1:0] prog_data;
  logic              busy, busy_prog, prog_err;
  logic [15:0]       busy_cnt;
  logic              apb_acc, apb_wr;
  logic [31:0]       next_prdata;
  logic [2:0]        r_sec;
  logic              prog_locked;

  // Pins come from another domain; addr and data must be held stable
  // Burst clock idles low; a high start would fake an edge
  frf_sync #(.W(SW), .INIT({7'h7b, {(AW + DATA_W){1'b0}}})) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .d       ({chip_sel_n, out_gate_n, write_n, address_valid_n,
                burst_clk, hw_reset_n, write_prot_n, addr, dq_in}),
    .q       (sync_q)
  );

  assign {s_ce_n, s_oe_n, s_we_n, s_adv_n, s_fclk, s_rst_n, s_wp_n,
          s_addr, s_dq} = sync_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      we_q   <= 1'b1;
      fclk_q <= 1'b0;
      rst_q  <= 1'b1;
    end else begin
      we_q   <= s_we_n;
      fclk_q <= s_fclk;
      rst_q  <= s_rst_n;
    end
  end

  assign we_rise   = s_we_n & ~we_q;
  assign fclk_rise = s_fclk & ~fclk_q;
  assign cmd_stb   = we_rise & ~s_ce_n & s_rst_n;
  assign burst_en  = cfg[CFG_BURST_BIT];

  // Reset pin restores async array read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MD_ARRAY;
      cfg  <= CFG_RESET;
    end else if (!s_rst_n) begin
      mode <= MD_ARRAY;
      cfg  <= CFG_RESET;
    end else if (cmd_stb) begin
      case (s_dq[31:24])
        CMD_RESET:   mode <= MD_ARRAY;
        CMD_CFG_RD:  mode <= MD_CFG;
        CMD_CFG_WR: begin
          cfg  <= s_dq[15:0];
          mode <= MD_ARRAY;
        end
        CMD_PROT_RD: mode <= MD_PROT;
        CMD_SECSI:   mode <= MD_SECSI;
        default:     mode <= mode;
      endcase
    end
  end

  // Burst sequencer on the system clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bs        <= BS_IDLE;
      b_base    <= '0;
      beat      <= 3'h0;
      wait_cnt  <= 5'h00;
      burst_bad <= 1'b0;
    end else if (!s_rst_n || s_ce_n || !burst_en ||
                 mode == MD_CFG || mode == MD_PROT) begin
      bs <= BS_IDLE;
    end else if (fclk_rise) begin
      if (!s_adv_n) begin
        bs       <= BS_WAIT;
        b_base   <= s_addr;
        beat     <= 3'h0;
        wait_cnt <= {1'b0, cfg[CFG_WAIT_LSB +: 4]} + WAIT_OFFSET;
        // Start past secured bound is invalid
        burst_bad <= (mode == MD_SECSI) &&
                     (s_addr >= AW'(SECSI_WORDS));
      end else begin
        case (bs)
          BS_WAIT: begin
            if (wait_cnt <= 5'h01) begin
              bs <= BS_DATA;
            end else begin
              wait_cnt <= wait_cnt - 5'h01;
            end
          end
          BS_DATA: beat <= beat + 3'h1;
          default: bs <= bs;
        endcase
      end
    end
  end

  // Linear burst wraps inside its aligned group of eight
  assign rd_addr = (bs == BS_IDLE) ? s_addr
                 : {b_base[AW-1:3], b_base[2:0] + beat};

  frf_mem #(.AW(AW), .DW(DATA_W)) u_mem (
    .ref_clk (ref_clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (rd_addr),
    .rdata   (mem_rdata)
  );

  assign r_sec = frf_sector(s_addr);

  // Output gate, select and reset control drive
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_oe  <= 1'b0;
      dq_out <= '0;
    end else begin
      dq_oe <= s_rst_n & ~s_ce_n & ~s_oe_n &
               (bs == BS_DATA || !burst_en ||
                mode == MD_CFG || mode == MD_PROT);
      case (mode)
        MD_CFG:  dq_out <= {16'h0000, cfg};
        // Persistent bit 0, dynamic bit 1
        MD_PROT: dq_out <= {30'h0, dynamic_protect_bit[r_sec], persistent_protect_bit[r_sec]};
        default: dq_out <= (bs != BS_IDLE && burst_bad) ? '0 : mem_rdata;
      endcase
    end
  end

  assign prog_locked = persistent_protect_bit[frf_sector(prog_addr)] |
                       dynamic_protect_bit[frf_sector(prog_addr)] |
                       (~s_wp_n & frf_outer(frf_sector(prog_addr)));

  assign apb_acc = psel & penable & ~pready;
  assign apb_wr  = psel & penable & pready & pwrite & frf_known(paddr);

  // Program engine and reset recovery share one busy counter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      busy_prog <= 1'b0;
      busy_cnt  <= 16'h0000;
      prog_err  <= 1'b0;
      mem_we    <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= '0;
    end else begin
      mem_we <= 1'b0;
      if (!s_rst_n && rst_q && busy) begin
        // Aborted program leaves a corrupt word
        if (busy_prog) begin
          mem_we    <= 1'b1;
          mem_waddr <= prog_addr;
          mem_wdata <= CORRUPT_WORD;
        end
        // Stay busy through internal reset handling
        busy_prog <= 1'b0;
        busy_cnt  <= 16'(RST_BUSY_CYC);
      end else if (busy) begin
        if (busy_cnt <= 16'h0001) begin
          busy <= 1'b0;
          if (busy_prog) begin
            mem_we    <= 1'b1;
            mem_waddr <= prog_addr;
            mem_wdata <= prog_data;
          end
          busy_prog <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - 16'h0001;
        end
      end else if (apb_wr && paddr == OFF_PDATA && s_rst_n) begin
        prog_err <= prog_locked;
        if (!prog_locked) begin
          busy      <= 1'b1;
          busy_prog <= 1'b1;
          busy_cnt  <= 16'(PROG_CYC);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_busy_n <= 1'b1;
    end else begin
      ready_busy_n <= ~busy;
    end
  end

  // Protection and program registers, written by software
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      persistent_protect_bit       <= PPB_RESET;
      dynamic_protect_bit       <= DYB_RESET;
      prog_addr <= '0;
      prog_data <= '0;
    end else if (apb_wr) begin
      case (paddr)
        OFF_PROT: begin
          persistent_protect_bit <= pwdata[7:0];
          dynamic_protect_bit <= pwdata[15:8];
        end
        OFF_PADDR: prog_addr <= busy ? prog_addr : pwdata[AW-1:0];
        OFF_PDATA: prog_data <= busy ? prog_data : pwdata;
        default:   persistent_protect_bit <= persistent_protect_bit;
      endcase
    end
  end

  always_comb begin
    next_prdata = 32'h0;
    case (paddr)
      OFF_STATUS: next_prdata = {26'h0, s_rst_n, prog_err, busy,
                                 burst_en, mode};
      OFF_CFG:    next_prdata = {16'h0, cfg};
      OFF_PROT:   next_prdata = {16'h0, dynamic_protect_bit, persistent_protect_bit};
      OFF_PADDR:  next_prdata = {{(32 - AW){1'b0}}, prog_addr};
      OFF_PDATA:  next_prdata = prog_data;
      default:    next_prdata = 32'h0;
    endcase
  end

  // One wait state keeps every bus output registered
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~frf_known(paddr);
      prdata  <= (apb_acc && !pwrite) ? next_prdata : 32'h0;
    end
  end

  // Checking helpers
  logic [4:0] wait_seen, wait_need;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_seen <= 5'h00;
      wait_need <= 5'h00;
    end else if (fclk_rise && !s_adv_n && bs != BS_IDLE) begin
      wait_seen <= 5'h00;
    end else if (fclk_rise && !s_adv_n) begin
      wait_seen <= 5'h00;
      wait_need <= {1'b0, cfg[CFG_WAIT_LSB +: 4]} + WAIT_OFFSET;
    end else if (fclk_rise && bs == BS_WAIT) begin
      wait_seen <= wait_seen + 5'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence seq_async_sel;
    (mode == MD_ARRAY && !burst_en && !s_ce_n && !s_oe_n && s_rst_n)[*3];
  endsequence

  sequence seq_rst_busy;
    $fell(s_rst_n) && busy;
  endsequence

  AST_DQ_GATE: assert property (dq_oe |-> $past(!s_ce_n && !s_oe_n))
    else $error("data driven while not selected or gated");
  AST_RST_FLOAT: assert property (!s_rst_n |=> !dq_oe)
    else $error("data driven during reset");
  AST_RST_MODE: assert property (!s_rst_n |=>
      mode == MD_ARRAY && cfg == CFG_RESET && bs == BS_IDLE)
    else $error("reset did not restore default state");
  AST_RB_HOLD: assert property (seq_rst_busy |=> !ready_busy_n[*2])
    else $error("ready_busy_n released early after reset");
  AST_CORRUPT: assert property (seq_rst_busy ##0 busy_prog |=>
      mem_we && mem_wdata == CORRUPT_WORD)
    else $error("aborted program did not corrupt word");
  AST_NO_BURST: assert property (!burst_en |=> bs == BS_IDLE)
    else $error("burst active while disabled");
  AST_WAIT: assert property ($rose(bs == BS_DATA) |->
      wait_seen == wait_need)
    else $error("initial wait count mismatch");
  AST_ASYNC_READ: assert property (seq_async_sel |=> dq_oe)
    else $error("async array read not driven");
  AST_CMD_HOLD: assert property (mode != $past(mode) |->
      $past(cmd_stb) || $past(!s_rst_n))
    else $error("mode changed without command");
  AST_PROT: assert property (mode == MD_PROT && $past(mode == MD_PROT) |->
      dq_out[31:2] == 30'h0)
    else $error("protection read has stray bits");
  AST_CFG_STABLE: assert property (mode == MD_CFG && $past(mode == MD_CFG) &&
      $stable(cfg) && dq_oe |=> $stable(dq_out))
    else $error("config read data not stable");

endmodule // frf_top
`default_nettype wire

// >>> testbench/frf_host.sv
// Host-side pin driver for the flash read/reset front end
`timescale 1ns/10ps
`default_nettype none
module frf_host
  import frf_pkg::*;
#(
  parameter int RECOV = 8
) (
  input  wire logic             ref_clk,
  output var logic              chip_sel_n,
  output var logic              out_gate_n,
  output var logic              write_n,
  output var logic              address_valid_n,
  output var logic              burst_clk,
  output var logic              hw_reset_n,
  output var logic              write_prot_n,
  output var logic [ADDR_W-1:0] addr,
  output var logic [DATA_W-1:0] dq_in
);
  initial begin
    chip_sel_n = 1'b1;
    out_gate_n = 1'b1;
    write_n = 1'b1;
    address_valid_n = 1'b1;
    burst_clk = 1'b0;
    hw_reset_n = 1'b0;
    write_prot_n = 1'b1;
    addr = '0;
    dq_in = '0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pins(input logic ce, input logic oe, input logic [7:0] a);
    @(posedge ref_clk);
    chip_sel_n <= ce;
    out_gate_n <= oe;
    addr <= a;
    wt(6);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    chip_sel_n <= 1'b0;
    out_gate_n <= 1'b1;
    dq_in <= {c, 8'h00, d};
    write_n <= 1'b0;
    wt(4);
    write_n <= 1'b1;
    wt(4);
    // Released bus must not keep the old word
    dq_in <= ~dq_in;
    chip_sel_n <= 1'b1;
    wt(2);
  endtask
  task automatic rst_pin(input logic v);
    @(posedge ref_clk);
    hw_reset_n <= v;
    wt(v ? RECOV : 6);
  endtask
  task automatic set_wp(input logic v);
    @(posedge ref_clk);
    write_prot_n <= v;
    wt(4);
  endtask
  // Burst clock idles low outside bursts; slow for the pin sync
  task automatic bclk();
    @(posedge ref_clk);
    burst_clk <= 1'b1;
    wt(8);
    burst_clk <= 1'b0;
    wt(8);
  endtask
  task automatic bstart(input logic [7:0] a);
    @(posedge ref_clk);
    chip_sel_n <= 1'b0;
    out_gate_n <= 1'b0;
    address_valid_n <= 1'b0;
    addr <= a;
    wt(4);
    bclk();
    address_valid_n <= 1'b1;
  endtask
endmodule // frf_host
`default_nettype wire

// >>> testbench/frf_top_tb.sv
// Self-checking testbench for the flash read/reset front end
`timescale 1ns/10ps
`default_nettype none
module frf_top_tb
  import frf_pkg::*;
;
  logic ref_clk = 1'b0, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed = 32'h5, pp;
  logic [DATA_W-1:0] dq_in, dq_out, d[8];
  logic cs_n, og_n, wr_n, adv_n, bclk, hrst_n, wp_n, dq_oe, ready_busy_n, er;
  logic [ADDR_W-1:0] addr;
  int fails = 0, samples_checked = 0, cyc = 0, st;

  frf_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_sel_n(cs_n),
    .out_gate_n(og_n), .write_n(wr_n), .address_valid_n(adv_n),
    .burst_clk(bclk), .hw_reset_n(hrst_n), .write_prot_n(wp_n),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .ready_busy_n(ready_busy_n));
  frf_host h (.ref_clk(ref_clk), .chip_sel_n(cs_n), .out_gate_n(og_n),
    .write_n(wr_n), .address_valid_n(adv_n), .burst_clk(bclk),
    .hw_reset_n(hrst_n), .write_prot_n(wp_n), .addr(addr), .dq_in(dq_in));

  always #5 ref_clk = ~ref_clk;
  // Ceiling well above the roughly 2600 cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] ad, logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a stuck transfer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrdy();
    int n = 0;
    repeat (4) @(posedge ref_clk);
    while (ready_busy_n !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check("ready_busy_n", {31'h0, ready_busy_n}, 32'h1);
  endtask
  task automatic prog(logic [7:0] ad, logic [31:0] wd);
    apb(1'b1, OFF_PADDR, {24'h0, ad});
    apb(1'b1, OFF_PDATA, wd);
    wrdy();
  endtask
  function automatic logic [31:0] stat(logic [1:0] m, logic b);
    return {27'h0, 2'b00, b, m};
  endfunction

  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    h.rst_pin(1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("status", {27'h0, rd[4:0]}, stat(MD_ARRAY, 1'b0));
    apb(1'b0, OFF_CFG, 32'h0);
    check("cfg", rd, {16'h0, CFG_RESET});
    // Random offset above the register map
    apb(1'b1, 8'h14 + 8'(4 * (rnd() % 59)), 32'h1);
    check("unmapped", {31'h0, er}, 32'h1);
    $display("reset state test done");
    for (int i = 0; i < 8; i++) begin
      d[i] = rnd();
      prog(8'h40 + 8'(i), d[i]);
    end
    for (int i = 0; i < 16; i++) begin
      st = int'(rnd() % 8);
      h.pins(1'b0, 1'b0, 8'h40 + 8'(st));
      check("dq_out", dq_out, d[st]);
      check("dq_oe", {31'h0, dq_oe}, 32'h1);
    end
    h.pins(1'b0, 1'b1, 8'h40);
    check("dq_oe gate", {31'h0, dq_oe}, 32'h0);
    h.pins(1'b1, 1'b0, 8'h40);
    check("dq_oe sel", {31'h0, dq_oe}, 32'h0);
    $display("async read test done");
    pp = rnd();
    apb(1'b1, OFF_PROT, {16'h0, pp[15:0]});
    h.cmd(CMD_PROT_RD, 16'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("mode", {30'h0, rd[1:0]}, {30'h0, MD_PROT});
    for (int s = 0; s < 8; s++) begin
      h.pins(1'b0, 1'b0, {3'(s), 5'h0});
      h.wt(10);
      check("prot", dq_out & 32'h3, {30'h0, pp[8+s], pp[s]});
    end
    h.cmd(CMD_RESET, 16'h0);
    h.pins(1'b0, 1'b0, 8'h41);
    check("array back", dq_out, d[1]);
    apb(1'b1, OFF_PROT, 32'h0);
    h.set_wp(1'b0);
    prog(8'h00, rnd());
    apb(1'b0, OFF_STATUS, 32'h0);
    check("prog_err", {31'h0, rd[4]}, 32'h1);
    h.set_wp(1'b1);
    $display("protection test done");
    h.cmd(CMD_CFG_RD, 16'h0);
    h.pins(1'b0, 1'b0, 8'h40);
    repeat (2) h.bclk();
    check("cfg read", {16'h0, dq_out[15:0]}, {16'h0, CFG_RESET});
    for (int f = 1; f < 4; f += 2) begin
      h.cmd(CMD_CFG_WR, 16'h8000 | 16'(f << CFG_WAIT_LSB));
      apb(1'b0, OFF_STATUS, 32'h0);
      check("burst_en", {31'h0, rd[2]}, 32'h1);
      st = int'(rnd() % 8);
      h.bstart(8'h40 + 8'(st));
      for (int k = 1; k < f + 2; k++) h.bclk();
      check("burst wait", {31'h0, dq_oe}, 32'h0);
      h.bclk();
      check("burst first", dq_out, d[st]);
      h.bclk();
      check("burst next", dq_out, d[(st+1)%8]);
      h.pins(1'b1, 1'b1, 8'h40);
    end
    h.cmd(CMD_SECSI, 16'h0);
    h.bstart(8'h40);
    // Wait field is still 3, so data on rise five
    repeat (5) h.bclk();
    check("secsi oe", {31'h0, dq_oe}, 32'h1);
    check("secsi bound", dq_out, 32'h0);
    h.pins(1'b1, 1'b1, 8'h40);
    $display("burst test done");
    // Config read keeps the bus driven up to the reset
    h.cmd(CMD_CFG_RD, 16'h0);
    apb(1'b1, OFF_PADDR, 32'h60);
    apb(1'b1, OFF_PDATA, rnd());
    h.pins(1'b0, 1'b0, 8'h41);
    check("oe pre reset", {31'h0, dq_oe}, 32'h1);
    h.rst_pin(1'b0);
    check("oe in reset", {31'h0, dq_oe}, 32'h0);
    h.rst_pin(1'b1);
    check("busy", {31'h0, ready_busy_n}, 32'h0);
    wrdy();
    apb(1'b0, OFF_STATUS, 32'h0);
    check("status rst", {27'h0, rd[4:0]}, stat(MD_ARRAY, 1'b0));
    h.pins(1'b0, 1'b0, 8'h60);
    check("corrupt", dq_out, CORRUPT_WORD);
    h.pins(1'b0, 1'b0, 8'h42);
    check("async again", dq_out, d[2]);
    $display("hardware reset test done");
    summarize();
  end
endmodule // frf_top_tb
`default_nettype wire
